// ==== dv/i2c_bus_protocol_engine_test.sv ====
// self-checking bench for the bus master against a slave and a rival
`timescale 1ns/1ps
module i2c_bus_protocol_engine_test import i2c_host_pkg::*;;
  localparam int         DLY = 2;
  localparam int         CEIL = 30000;
  localparam logic [6:0] SLV = 7'h2A;
  typedef struct {
    logic st, sp, rd, last;
    logic [6:0] a;
    logic [7:0] wd;
    int str;
    logic ack;
    logic [7:0] exp;
  } row_t;

  logic       core_clk, reset, cmd_valid, cmd_ready, cmd_start, cmd_stop;
  logic       cmd_read, cmd_last, done, ack_rcvd, arb_lost, bus_busy;
  logic       bus_owned, scl_oe, sda_oe, scl_pull, sda_pull, r_scl, r_sda;
  logic [6:0] cmd_addr;
  logic [7:0] cmd_wdata, rd_data, rx_byte;
  int         stretch, n_fail, comparisons, cycles;
  wire logic  scl_w = ~(scl_oe | scl_pull | r_scl);
  wire logic  sda_w = ~(sda_oe | sda_pull | r_sda);
  row_t       rows [8];

  i2c_bus_master #(.QUARTER(4)) dut (
    .core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
    .cmd_read(cmd_read), .cmd_last(cmd_last), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .done(done), .ack_rcvd(ack_rcvd),
    .rd_data(rd_data), .arb_lost(arb_lost), .bus_busy(bus_busy),
    .bus_owned(bus_owned), .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe));

  i2c_slave_model #(.ADDR(SLV)) slave (
    .scl(scl_w), .sda(sda_w), .tx_byte(8'hC3), .stretch_ns(stretch),
    .scl_pull(scl_pull), .sda_pull(sda_pull), .rx_byte(rx_byte));

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #DLY;
  endtask : tick

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic send(input row_t r);
    cmd_start = r.st;
    cmd_stop = r.sp;
    cmd_read = r.rd;
    cmd_last = r.last;
    cmd_addr = r.a;
    cmd_wdata = r.wd;
    stretch = r.str;
    cmd_valid = 1'h1;
    while (cmd_ready !== 1'h1) tick(1);
    tick(1);
    cmd_valid = 1'h0;
  endtask : send

  task automatic run(input row_t r);
    send(r);
    while (done !== 1'h1) tick(1);
    chk("ack_rcvd", {7'h00, r.ack}, {7'h00, ack_rcvd});
    chk("rd_data", r.exp, rd_data);
    if (!r.st && !r.rd) chk("rx_byte", r.wd, rx_byte);
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == CEIL) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    row_t arb;
    int n;
    rows = '{
      '{1'h1, 1'h0, 1'h0, 1'h0, SLV,   8'h00, 0,    1'h1, 8'h54},
      '{1'h0, 1'h0, 1'h0, 1'h0, 7'h00, 8'hA5, 0,    1'h1, 8'hA5},
      '{1'h1, 1'h0, 1'h1, 1'h0, SLV,   8'h00, 0,    1'h1, 8'h55},
      '{1'h0, 1'h0, 1'h1, 1'h0, 7'h00, 8'h00, 0,    1'h1, 8'hC3},
      '{1'h0, 1'h1, 1'h1, 1'h1, 7'h00, 8'h00, 0,    1'h0, 8'h3C},
      '{1'h1, 1'h1, 1'h0, 1'h0, 7'h11, 8'h00, 0,    1'h0, 8'h22},
      '{1'h1, 1'h0, 1'h0, 1'h0, SLV,   8'h00, 1500, 1'h1, 8'h54},
      '{1'h0, 1'h1, 1'h0, 1'h0, 7'h00, 8'h81, 1500, 1'h1, 8'h81}};
    arb = '{1'h1, 1'h0, 1'h0, 1'h0, 7'h50, 8'h00, 0, 1'h0, 8'h00};
    n_fail = 0;
    comparisons = 0;
    cycles = 0;
    reset = 1'h1;
    {cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_last} = 5'h00;
    cmd_addr = 7'h00;
    cmd_wdata = 8'h00;
    stretch = 0;
    {r_scl, r_sda} = 2'h0;
    tick(1);
    chk("reset lines", 8'h00, {6'h00, scl_oe, sda_oe});
    chk("reset flags", 8'h00, {5'h00, done, arb_lost, bus_owned});
    tick(1);
    reset = 1'h0;
    // write, restart into read, nack probe, stretched write
    foreach (rows[i]) run(rows[i]);
    // last stop waits out the slave's clock hold first
    tick(120);
    chk("idle", 8'h00, {4'h0, bus_owned, bus_busy, scl_oe, sda_oe});
    // a rival start blocks us, a stop without a low clock is ignored
    stretch = 0;
    cmd_start = 1'h1;
    r_sda = 1'h1;
    tick(6);
    chk("bus_busy", 8'h01, {7'h00, bus_busy});
    chk("cmd_ready", 8'h00, {7'h00, cmd_ready});
    r_sda = 1'h0;
    tick(6);
    chk("bus_busy", 8'h01, {7'h00, bus_busy});
    r_sda = 1'h1;
    tick(6);
    r_scl = 1'h1;
    tick(6);
    r_scl = 1'h0;
    tick(6);
    r_sda = 1'h0;
    tick(6);
    chk("bus_busy", 8'h00, {7'h00, bus_busy});
    chk("cmd_ready", 8'h01, {7'h00, cmd_ready});
    // rival holds data low on our first released address bit
    send(arb);
    while (scl_oe !== 1'h1) tick(1);
    tick(1);
    r_sda = 1'h1;
    n = 0;
    while (arb_lost !== 1'h1 && n < 2000) begin
      tick(1);
      n++;
    end
    chk("arb_lost", 8'h01, {7'h00, arb_lost});
    tick(1);
    chk("lost lines", 8'h00, {6'h00, scl_oe, sda_oe});
    chk("cmd_ready", 8'h00, {7'h00, cmd_ready});
    r_sda = 1'h0;
    tick(8);
    chk("bus_busy", 8'h00, {7'h00, bus_busy});
    run('{1'h1, 1'h1, 1'h0, 1'h0, SLV, 8'h00, 0, 1'h1, 8'h54});
    stop_test();
  end
endmodule : i2c_bus_protocol_engine_test

// ==== dv/i2c_slave_model.sv ====
// behavioural slave on the two-wire bus: ack, read data, clock stretching
`timescale 1ns/1ps
module i2c_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  // wired line levels
  input  wire logic       scl,
  input  wire logic       sda,
  // first read byte, later bytes alternate with its complement
  input  wire logic [7:0] tx_byte,
  // clock hold after each falling edge, zero for none
  input  wire integer     stretch_ns,
  // open-drain pulls, one pulls the line low
  output logic            scl_pull,
  output logic            sda_pull,
  // last data byte written to us
  output logic [7:0]      rx_byte
);
  int         bitn;
  logic       act, addr_ph, sel, rd, nack, txing, odd, low_seen;
  logic [7:0] sh, tx;

  initial begin
    scl_pull = 1'h0;
    sda_pull = 1'h0;
    rx_byte  = 8'h00;
    act      = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // start resets the phase flags and bit count but not sda_pull, a restart as well
  always @(negedge sda) if (scl) begin
    act = 1'h1;
    addr_ph = 1'h1;
    sel = 1'h0;
    txing = 1'h0;
    odd = 1'h0;
    low_seen = 1'h0;
    bitn = 0;
  end

  // stop counts only once the clock has been low since the start
  always @(posedge sda) if (scl && act && low_seen) begin
    act = 1'h0;
    sda_pull = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge scl) if (act) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    else nack = sda;
    bitn = bitn + 1;
  end

  // data moves a little after the fall, well inside the low phase
  always @(negedge scl) if (act) begin
    low_seen = 1'h1;
    #50;
    if (bitn == 8) begin
      if (addr_ph) begin
        sel = (sh[7:1] == ADDR);
        rd = sh[0];
        addr_ph = 1'h0;
        sda_pull = sel;
      end else begin
        sda_pull = sel && !rd;
        if (sel && !rd) rx_byte = sh;
      end
      txing = 1'h0;
    end else if (bitn == 9) begin
      bitn = 0;
      txing = sel && rd && !nack;
      tx = tx_byte ^ {8{odd}};
      odd = !odd;
      sda_pull = txing && !tx[7];
    end else if (txing) begin
      sda_pull = !tx[7 - bitn];
    end
  end

  always @(negedge scl) if (act && stretch_ns > 0) begin
    scl_pull = 1'h1;
    #(stretch_ns);
    scl_pull = 1'h0;
  end
endmodule : i2c_slave_model

// ==== hdl/i2c_bus_master.sv ====
// byte-level two-wire bus master with arbitration and stretch support
`timescale 1ns/1ps
module i2c_bus_master
  import i2c_host_pkg::*;
#(
  parameter int unsigned QUARTER = SCL_QUARTER_CYC,
  parameter int unsigned CNT_W   = 10
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // command
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_start,
  input  wire logic       cmd_stop,
  input  wire logic       cmd_read,
  input  wire logic       cmd_last,
  input  wire logic [6:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  // result
  output logic            done,
  output logic            ack_rcvd,
  output logic [7:0]      rd_data,
  output logic            arb_lost,
  output logic            bus_busy,
  output logic            bus_owned,
  // clock line
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  // data line
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe
);

  localparam logic [CNT_W-1:0] Q_END = CNT_W'(QUARTER - 1);
  localparam logic [CNT_W-1:0] H_END = CNT_W'(2 * QUARTER - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  typedef struct packed {
    state_t           st;
    logic [CNT_W-1:0] cnt;
    logic [3:0]       bit_idx;
    logic [7:0]       sh;
    logic             tx;
    logic             rd_dir;
    logic             last;
    logic             stop;
    logic             own;
    logic             seen_high;
    logic             scl_oe;
    logic             sda_oe;
    logic             done;
    logic             arb_lost;
    logic             ack;
    logic [7:0]       rdata;
  } ctl_t;

  ctl_t r;
  ctl_t nxt;
  logic scl_s;
  logic sda_s;
  logic samp;
  logic accept;

  ////////////////////////////////////////////////////////////////////////////
  // line synchronisers and bus condition tracking

  i2c_line_sync u_scl_sync (
    .core_clk  (core_clk),
    .reset     (reset),
    .line_in   (scl_i),
    .line_sync (scl_s)
  );

  i2c_line_sync u_sda_sync (
    .core_clk  (core_clk),
    .reset     (reset),
    .line_in   (sda_i),
    .line_sync (sda_s)
  );

  i2c_bus_monitor u_monitor (
    .core_clk   (core_clk),
    .reset      (reset),
    .scl_s      (scl_s),
    .sda_s      (sda_s),
    .start_seen (),
    .stop_seen  (),
    .bus_busy   (bus_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command handshake

  // a fresh message waits for an idle bus unless we already hold it
  assign cmd_ready = (r.st == S_IDLE)
                     && (r.own || (cmd_start && !bus_busy));
  assign accept    = cmd_valid && cmd_ready;
  // first cycle of a clock high phase actually seen on the line
  assign samp      = (r.st == S_HIGH) && !r.seen_high && scl_s;

  ////////////////////////////////////////////////////////////////////////////
  // bus sequencer

  always_comb begin
    nxt          = r;
    nxt.done     = 1'b0;
    nxt.arb_lost = 1'b0;
    case (r.st)
      S_IDLE: begin
        if (accept) begin
          nxt.stop    = cmd_stop;
          nxt.last    = cmd_last;
          nxt.bit_idx = BIT_FIRST;
          nxt.cnt     = '0;
          if (cmd_start) begin
            nxt.sh     = {cmd_addr, cmd_read};
            nxt.rd_dir = cmd_read;
            nxt.tx     = 1'b1;
            if (r.own) begin
              nxt.st = S_RS_A;
            end else begin
              nxt.sda_oe = 1'b1;
              nxt.st     = S_START;
            end
          end else begin
            // roles follow the direction bit
            nxt.tx = !r.rd_dir;
            nxt.sh = r.rd_dir ? RX_FILL : cmd_wdata;
            nxt.st = S_LOW;
          end
        end
      end
      S_START: begin
        nxt.cnt = r.cnt + CNT_ONE;
        if (r.cnt == H_END) begin
          nxt.scl_oe = 1'b1;
          nxt.own    = 1'b1;
          nxt.cnt    = '0;
          nxt.st     = S_LOW;
        end
      end
      S_LOW: begin
        nxt.cnt = r.cnt + CNT_ONE;
        // data moves a quarter after the falling edge
        if (r.cnt == Q_END) begin
          if (r.bit_idx == BIT_ACK) begin
            // transmitter lets go, receiver acks unless last
            nxt.sda_oe = !r.tx && !r.last;
          end else begin
            nxt.sda_oe = r.tx && !r.sh[7];
          end
        end
        if (r.cnt == H_END) begin
          nxt.scl_oe    = 1'b0;
          nxt.cnt       = '0;
          nxt.seen_high = 1'b0;
          nxt.st        = S_HIGH;
        end
      end
      S_HIGH: begin
        // a stretched clock holds us here with the count parked
        if (samp) begin
          nxt.seen_high = 1'b1;
          if (r.bit_idx == BIT_ACK) begin
            nxt.ack = r.tx ? !sda_s : !r.last;
          end else begin
            nxt.sh = {r.sh[6:0], sda_s};
            // released high but read low: someone else owns the bus
            if (r.tx && !r.sda_oe && !sda_s) begin
              nxt.st       = S_LOST;
              nxt.scl_oe   = 1'b0;
              nxt.sda_oe   = 1'b0;
              nxt.arb_lost = 1'b1;
              nxt.own      = 1'b0;
            end
          end
        end else if (r.seen_high) begin
          nxt.cnt = r.cnt + CNT_ONE;
          if (r.cnt == H_END) begin
            nxt.cnt    = '0;
            nxt.scl_oe = 1'b1;
            if (r.bit_idx == BIT_ACK) begin
              nxt.done  = 1'b1;
              nxt.rdata = r.sh;
              nxt.st    = r.stop ? S_STOP_A : S_IDLE;
            end else begin
              nxt.bit_idx = r.bit_idx + 4'h1;
              nxt.st      = S_LOW;
            end
          end
        end
      end
      S_STOP_A: begin
        nxt.cnt = r.cnt + CNT_ONE;
        if (r.cnt == Q_END) begin
          nxt.sda_oe = 1'b1;
        end
        if (r.cnt == H_END) begin
          nxt.scl_oe = 1'b0;
          nxt.cnt    = '0;
          nxt.st     = S_STOP_B;
        end
      end
      S_STOP_B: begin
        nxt.cnt = scl_s ? r.cnt + CNT_ONE : '0;
        if (scl_s && r.cnt == H_END) begin
          nxt.sda_oe = 1'b0;
          nxt.cnt    = '0;
          nxt.st     = S_STOP_C;
        end
      end
      S_STOP_C: begin
        // bus free time before another start
        nxt.cnt = r.cnt + CNT_ONE;
        if (r.cnt == H_END) begin
          nxt.own = 1'b0;
          nxt.cnt = '0;
          nxt.st  = S_IDLE;
        end
      end
      S_RS_A: begin
        nxt.cnt = r.cnt + CNT_ONE;
        if (r.cnt == Q_END) begin
          nxt.sda_oe = 1'b0;
        end
        if (r.cnt == H_END) begin
          nxt.scl_oe = 1'b0;
          nxt.cnt    = '0;
          nxt.st     = S_RS_B;
        end
      end
      S_RS_B: begin
        nxt.cnt = scl_s ? r.cnt + CNT_ONE : '0;
        if (scl_s && r.cnt == H_END) begin
          // slaves reset on this as on any start
          nxt.sda_oe = 1'b1;
          nxt.cnt    = '0;
          nxt.st     = S_START;
        end
      end
      S_LOST: begin
        if (!bus_busy) begin
          nxt.st = S_IDLE;
        end
      end
      default: begin
        nxt = '{st: S_IDLE, default: '0};
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      r <= '{st: S_IDLE, default: '0};
    end else begin
      r <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // open-drain: output data is always low, only the enables move
  assign scl_o     = LINE_LOW;
  assign sda_o     = LINE_LOW;
  assign scl_oe    = r.scl_oe;
  assign sda_oe    = r.sda_oe;
  assign done      = r.done;
  assign ack_rcvd  = r.ack;
  assign rd_data   = r.rdata;
  assign arb_lost  = r.arb_lost;
  assign bus_owned = r.own;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_open_drain;
    (scl_oe || sda_oe) |-> (scl_o == LINE_LOW && sda_o == LINE_LOW);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("line driven to a high level");

  property p_start_shape;
    $rose(sda_oe) && !scl_oe |-> r.st == S_START;
  endproperty
  a_start_shape: assert property (p_start_shape)
    else $error("data pulled low under high clock outside start");

  property p_stop_shape;
    $fell(sda_oe) && !scl_oe |-> (r.st == S_STOP_C || r.st == S_LOST);
  endproperty
  a_stop_shape: assert property (p_stop_shape)
    else $error("data released under high clock outside stop");

  property p_data_stable;
    (r.st == S_HIGH && $past(r.st) == S_HIGH) |-> $stable(sda_oe);
  endproperty
  a_data_stable: assert property (p_data_stable)
    else $error("data changed while clock high");

  property p_dir_bit;
    accept && cmd_start |=> (r.sh[0] == $past(cmd_read)) && r.tx;
  endproperty
  a_dir_bit: assert property (p_dir_bit)
    else $error("direction bit not loaded from command");

  property p_msb_first;
    (r.st == S_LOW && r.cnt == Q_END && r.tx && r.bit_idx != BIT_ACK)
      |=> sda_oe == !$past(r.sh[7]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("bit sent is not the top of the shifter");

  property p_ack_release;
    (r.st == S_HIGH && r.bit_idx == BIT_ACK && r.tx) |-> !sda_oe;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("transmitter holds data during acknowledge");

  property p_rx_ack;
    (r.st == S_HIGH && r.bit_idx == BIT_ACK && !r.tx) |-> sda_oe == !r.last;
  endproperty
  a_rx_ack: assert property (p_rx_ack)
    else $error("receiver acknowledge wrong for last flag");

  property p_stretch_wait;
    (r.st == S_HIGH && !r.seen_high && !scl_s) |=>
      (r.st == S_HIGH && !scl_oe && !r.seen_high);
  endproperty
  a_stretch_wait: assert property (p_stretch_wait)
    else $error("bit advanced while the clock was held low");

  property p_busy_block;
    (accept && !r.own) |-> !bus_busy;
  endproperty
  a_busy_block: assert property (p_busy_block)
    else $error("new message accepted on a busy bus");

  property p_arb_loss;
    (samp && r.tx && !r.sda_oe && !sda_s && r.bit_idx != BIT_ACK)
      |=> arb_lost && !sda_oe && !scl_oe && r.st == S_LOST;
  endproperty
  a_arb_loss: assert property (p_arb_loss)
    else $error("mismatch on data line did not drop arbitration");

  property p_lost_wait;
    (r.st == S_LOST && bus_busy) |=> r.st == S_LOST && !scl_oe && !sda_oe;
  endproperty
  a_lost_wait: assert property (p_lost_wait)
    else $error("left lost state before the bus went idle");

  property p_lost_report;
    arb_lost |-> r.st == S_LOST && !bus_owned;
  endproperty
  a_lost_report: assert property (p_lost_report)
    else $error("arbitration loss reported outside lost state");

  c_read_byte: cover property (done && !r.tx);
  c_arb_lost:  cover property (arb_lost);
  c_restart:   cover property (r.st == S_RS_B ##1 r.st == S_START);
  // longer than the synchroniser delay, so only a held clock hits it
  c_stretch:   cover property ((r.st == S_HIGH && !scl_s) [*8]);

endmodule : i2c_bus_master

// ==== hdl/i2c_bus_monitor.sv ====
// start, stop and bus-busy tracking on synchronised lines
`timescale 1ns/1ps
module i2c_bus_monitor
  import i2c_host_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // synchronised lines
  input  wire logic scl_s,
  input  wire logic sda_s,
  // bus conditions
  output logic      start_seen,
  output logic      stop_seen,
  output logic      bus_busy
);

  typedef struct packed {
    logic scl_q;
    logic sda_q;
    logic low_seen;
    logic busy;
    logic start_p;
    logic stop_p;
  } mon_t;

  mon_t r;
  mon_t nxt;
  logic is_start;
  logic is_stop;

  assign is_start = r.scl_q && scl_s && r.sda_q && !sda_s;
  // a stop needs one low clock since the start
  assign is_stop  = r.scl_q && scl_s && !r.sda_q && sda_s
                    && r.low_seen;

  always_comb begin
    nxt         = r;
    nxt.scl_q   = scl_s;
    nxt.sda_q   = sda_s;
    nxt.start_p = is_start;
    nxt.stop_p  = is_stop;
    if (is_start) begin
      nxt.busy     = 1'b1;
      nxt.low_seen = 1'b0;
    end else if (!scl_s) begin
      nxt.low_seen = 1'b1;
    end
    if (is_stop) begin
      nxt.busy = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      r <= '{scl_q: LINE_IDLE, sda_q: LINE_IDLE, default: '0};
    end else begin
      r <= nxt;
    end
  end

  assign start_seen = r.start_p;
  assign stop_seen  = r.stop_p;
  assign bus_busy   = r.busy;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_stop_after_low;
    stop_seen |-> $past(r.low_seen);
  endproperty
  a_stop_after_low: assert property (p_stop_after_low)
    else $error("stop flagged without a low clock since start");

endmodule : i2c_bus_monitor

// ==== hdl/i2c_host_pkg.sv ====
// shared constants and state codes for the two-wire bus master
package i2c_host_pkg;

  // core clock and bit timing
  localparam int unsigned CORE_PERIOD_NS  = 25;
  localparam int unsigned SCL_PERIOD_NS   = 10000;
  // a quarter of the bit time is a least time: round up
  localparam int unsigned SCL_QUARTER_CYC =
    (SCL_PERIOD_NS / 4 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

  // bit positions within a nine-bit segment
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_ACK   = 4'h8;

  // released line level and driven level
  localparam logic LINE_IDLE = 1'b1;
  localparam logic LINE_LOW  = 1'b0;

  // byte loaded while receiving, keeps the data line released
  localparam logic [7:0] RX_FILL = 8'hFF;

  typedef enum logic [9:0] {
    S_IDLE   = 10'h001,
    S_START  = 10'h002,
    S_LOW    = 10'h004,
    S_HIGH   = 10'h008,
    S_STOP_A = 10'h010,
    S_STOP_B = 10'h020,
    S_STOP_C = 10'h040,
    S_RS_A   = 10'h080,
    S_RS_B   = 10'h100,
    S_LOST   = 10'h200
  } state_t;

endpackage : i2c_host_pkg

// ==== hdl/i2c_line_sync.sv ====
// two-stage synchroniser for one bus line
`timescale 1ns/1ps
module i2c_line_sync
  import i2c_host_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // line in, synchronised level out
  input  wire logic line_in,
  output logic      line_sync
);

  typedef struct packed {
    logic meta;
    logic q;
  } sync_t;

  sync_t r;
  sync_t nxt;

  // the first stage feeds only the second
  always_comb begin
    nxt      = r;
    nxt.meta = line_in;
    nxt.q    = r.meta;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      r <= '{meta: LINE_IDLE, q: LINE_IDLE};
    end else begin
      r <= nxt;
    end
  end

  assign line_sync = r.q;

endmodule : i2c_line_sync
